// ==== verilog/adc_parallel_control_port.sv ====
// Control word, sequencing and result readout of a 12-bit SAR converter
// ------------------------------------------------------------
// ------------------------------------------------------------
module adc_parallel_control_port
  import adc_ctl_pkg::*;
#(
  parameter int ACQ_CLKS = ACQ_TICKS  // Acquisition length in ticks
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              deviceSelectN,  // Chip select
  input  wire logic              writeStrobeN,   // Write strobe
  input  wire logic              readStrobeN,    // Read strobe
  input  wire logic              highByteSelect, // Result half select
  input  wire logic              convClk,        // External conversion clock
  input  wire logic [DATA_W-1:0] dataIn,         // Bus level in
  output logic      [DATA_W-1:0] dataOut,        // Bus level driven
  output logic                   dataOeN,        // Low while driving bus
  output logic                   doneFlagN,      // Result ready, low
  input  wire logic              compAbove,      // Input above DAC trial
  output logic      [RES_W-1:0]  dacCode,        // SAR trial code
  output logic                   trackHold,      // High while acquiring
  output logic      [CHAN_W-1:0] posInput,       // Positive input index
  output logic      [CHAN_W-1:0] negInput,       // Negative input index
  output logic                   negIsCommon,    // Negative is common ref
  output logic                   biasOn,         // Low only in shutdown
  output logic                   converterOn     // High in normal power
);

  // ----------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------
  if (ACQ_CLKS < 1 || ACQ_CLKS > 31) begin : g_bad_acq
    $error("ACQ_CLKS must lie in 1..31");
  end

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  logic [DATA_W-1:0] ctl_reg;         // Last control word
  logic              extClkMode_reg;  // Conversion clock source
  logic              wrPrev_reg;      // Write strobe last cycle
  logic              rdPrev_reg;      // Read active last cycle
  logic              clkPrev_reg;     // Conversion clock last cycle
  phase_e            phase_reg;       // Sequencer phase
  power_e            pwr_reg;         // Power state
  logic [CNT_W-1:0]  cnt_reg;         // Ticks within phase
  logic [RES_W-1:0]  sar_reg;         // Bits decided so far
  logic [RES_W-1:0]  result_reg;      // Held result
  logic              resUni_reg;      // Polarity of held result
  logic              done_reg;        // Done flag, active high
  logic              wrEvent;         // Selected write strobe rise
  logic              rdActive;        // Selected read in progress
  logic              rdStart;         // First cycle of a read
  logic              tick;            // Converter clock step
  logic              convDone;        // Last conversion tick
  logic [CNT_W-1:0]  lastCnt;         // Final conversion tick index
  logic [RES_W-1:0]  trialBit;        // Bit under trial

  // Pick the trial bit for a step index
  function automatic logic [RES_W-1:0] trial(input logic [CNT_W-1:0] idx);
    logic [RES_W-1:0] t;
    t = '0;
    if (idx < CNT_W'(RES_W)) begin
      t = RES_W'(1) << (CNT_W'(RES_W) - CNT_W'(1) - idx);
    end
    return t;
  endfunction

  // ----------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------
  // Strobes only count while selected
  assign wrEvent  = !deviceSelectN && writeStrobeN && !wrPrev_reg;
  assign rdActive = !deviceSelectN && !readStrobeN;
  assign rdStart  = rdActive && !rdPrev_reg;
  // External clock edges are ignored while deselected
  assign tick = extClkMode_reg ? (!deviceSelectN && convClk && !clkPrev_reg) : 1'b1;

  // Edge history of the strobes and clock pin
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPrev_reg  <= 1'b1;
      rdPrev_reg  <= 1'b0;
      clkPrev_reg <= 1'b0;
    end else begin
      wrPrev_reg  <= writeStrobeN;
      rdPrev_reg  <= rdActive;
      clkPrev_reg <= convClk;
    end
  end

  // ----------------------------------------------------------
  // Control word and clock mode
  // ----------------------------------------------------------
  // Capture the word; only normal-power codes move the clock mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_reg        <= CTL_RESET;
      extClkMode_reg <= 1'b1;
    end else if (wrEvent) begin
      ctl_reg <= dataIn;
      if (dataIn[CTL_PWR_HI]) begin
        extClkMode_reg <= dataIn[CTL_PWR_LO];
      end
    end
  end

  // ----------------------------------------------------------
  // Power state
  // ----------------------------------------------------------
  // Any write wakes the part; a power-down word takes hold once
  // its conversion ends, so a running conversion is never cut
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_reg <= PS_NORMAL;
    end else if (wrEvent) begin
      pwr_reg <= PS_NORMAL;
    end else if (convDone && !ctl_reg[CTL_PWR_HI]) begin
      pwr_reg <= ctl_reg[CTL_PWR_LO] ? PS_STANDBY : PS_SHUTDOWN;
    end
  end

  // The bus logic stays clocked in every power state
  assign biasOn      = (pwr_reg != PS_SHUTDOWN);
  assign converterOn = (pwr_reg == PS_NORMAL);

  // ----------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------
  // Internal clock runs the steps on consecutive cycles, then idles to fill the fixed conversion time
  assign lastCnt  = extClkMode_reg ? CNT_W'(CONV_TICKS - 1) : CNT_W'(INT_CONV_CYCLES - 1);
  assign convDone = (phase_reg == PH_CONV) && tick && (cnt_reg == lastCnt);
  assign trialBit = trial(cnt_reg);
  assign dacCode  = sar_reg | trialBit;
  assign trackHold = (phase_reg == PH_ACQ);

  // Write starts acquisition; external acquisition ends on the
  // second write, internal on a fixed tick count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= PH_IDLE;
      cnt_reg   <= '0;
      sar_reg   <= '0;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          if (wrEvent) begin
            phase_reg <= PH_ACQ;
            cnt_reg   <= '0;
          end
        end
        PH_ACQ: begin
          // Acquisition mode bit is the one of the current word
          if (ctl_reg[CTL_ACQ] ? wrEvent : (tick && cnt_reg == CNT_W'(ACQ_CLKS - 1))) begin
            phase_reg <= PH_CONV;
            cnt_reg   <= '0;
            sar_reg   <= '0;
          end else if (tick && !ctl_reg[CTL_ACQ]) begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        PH_CONV: begin
          // Writes here replace the whole word; the phase does not restart
          if (tick) begin
            if (compAbove) begin
              sar_reg <= sar_reg | trialBit;
            end
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == lastCnt) begin
              phase_reg <= PH_IDLE;
            end
          end
        end
        default: begin
          phase_reg <= PH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Result register
  // ----------------------------------------------------------
  // Bipolar codes arrive offset-binary; flipping the MSB gives
  // two's complement. Held until the next conversion ends.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result_reg <= '0;
      resUni_reg <= 1'b1;
    end else if (convDone) begin
      result_reg <= (sar_reg | (compAbove ? trialBit : '0)) ^
                    {!ctl_reg[CTL_UNI], {(RES_W-1){1'b0}}};
      resUni_reg <= ctl_reg[CTL_UNI];
    end
  end

  // ----------------------------------------------------------
  // Done flag
  // ----------------------------------------------------------
  // A finishing conversion wins over a read or write clearing it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      done_reg <= 1'b0;
    end else if (convDone) begin
      done_reg <= 1'b1;
    end else if (rdStart || wrEvent) begin
      done_reg <= 1'b0;
    end
  end
  assign doneFlagN = !done_reg;

  // ----------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------
  // Bus data registered each cycle; settles one cycle after a
  // change of the half select or the result
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dataOut <= '0;
    end else if (highByteSelect) begin
      dataOut <= {resUni_reg ? 4'h0 : {4{result_reg[RES_W-1]}},
                  result_reg[RES_W-1:DATA_W]};
    end else begin
      dataOut <= result_reg[DATA_W-1:0];
    end
  end
  // Drive only while selected and read strobe low
  assign dataOeN = !rdActive;

  // ----------------------------------------------------------
  // Channel multiplexer
  // ----------------------------------------------------------
  // Differential pairs share bits 2..1; bit 0 swaps polarity
  always_comb begin
    posInput    = ctl_reg[CTL_CHAN_MSB:0];
    negIsCommon = ctl_reg[CTL_SGL];
    negInput    = {ctl_reg[CTL_CHAN_MSB:1], !ctl_reg[0]};
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_float_deselect: assert property (deviceSelectN |-> dataOeN)
    else $error("Bus driven while deselected");
  a_word_capture: assert property (wrEvent |=> ctl_reg == $past(dataIn))
    else $error("Control word not captured");
  a_low_byte: assert property (!highByteSelect |=> dataOut == $past(result_reg[7:0]))
    else $error("Low byte wrong");
  a_high_nibble: assert property (highByteSelect |=> dataOut[3:0] == $past(result_reg[11:8]))
    else $error("High nibble wrong");
  a_high_sign: assert property (highByteSelect |=>
      dataOut[7:4] == ($past(resUni_reg) ? 4'h0 : {4{$past(result_reg[11])}}))
    else $error("Upper bits not zero or sign");
  a_done_sets: assert property (convDone |=> !doneFlagN && resUni_reg == $past(ctl_reg[CTL_UNI]))
    else $error("Done flag not set on completion");
  a_done_clears: assert property ((rdStart || wrEvent) && !convDone |=> doneFlagN)
    else $error("Done flag not released");
  a_clk_mode_keep: assert property (wrEvent && !dataIn[7] |=> $stable(extClkMode_reg))
    else $error("Power-down changed clock mode");
  a_int_conv_time: assert property ($rose(phase_reg == PH_CONV) && !extClkMode_reg |-> ##35 convDone)
    else $error("Internal conversion length wrong");
  a_shutdown_wait: assert property (phase_reg == PH_CONV && !convDone && pwr_reg == PS_NORMAL
      |=> pwr_reg == PS_NORMAL)
    else $error("Powered down mid-conversion");
  a_wake_write: assert property (wrEvent && pwr_reg != PS_NORMAL |=> pwr_reg == PS_NORMAL)
    else $error("Write strobe did not wake");
  a_result_hold: assert property (!convDone |=> $stable(result_reg))
    else $error("Result changed without completion");

endmodule

// ==== shared/adc_ctl_pkg.sv ====
// Constants and types shared by the converter control port
package adc_ctl_pkg;
  // ----------------------------------------------------------
  // Bus and result widths
  // ----------------------------------------------------------
  localparam int DATA_W = 8;    // Byte-wide shared bus
  localparam int RES_W  = 12;   // Result width
  localparam int CHAN_W = 3;    // Channel code width
  localparam int CNT_W  = 6;    // Phase counter width
  // ----------------------------------------------------------
  // Control word field positions
  // ----------------------------------------------------------
  localparam int CTL_PWR_HI   = 7;
  localparam int CTL_PWR_LO   = 6;
  localparam int CTL_ACQ      = 5;
  localparam int CTL_SGL      = 4;
  localparam int CTL_UNI      = 3;
  localparam int CTL_CHAN_MSB = 2;
  // Control word after reset: normal power, external clock
  localparam logic [7:0] CTL_RESET = 8'hc0;
  // Power control codes
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY   = 2'h1;
  localparam logic [1:0] PWR_INT_CLK   = 2'h2;
  localparam logic [1:0] PWR_EXT_CLK   = 2'h3;
  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int ACQ_TICKS        = 3;    // Acquisition clocks
  localparam int CONV_TICKS       = 13;   // Conversion clocks
  localparam int CLK_PERIOD_NS    = 100;  // ref_clk period
  localparam int INT_CONV_TIME_NS = 3600; // Internal clock conversion
  localparam int INT_CONV_CYCLES  =
    (INT_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------
  // States
  // ----------------------------------------------------------
  typedef enum logic [1:0] {PH_IDLE, PH_ACQ, PH_CONV} phase_e;
  typedef enum logic [1:0] {PS_NORMAL, PS_STANDBY, PS_SHUTDOWN} power_e;
endpackage

// ==== verif/host_bus_model.sv ====
// Host microprocessor model on the shared byte bus
module host_bus_model
  import adc_ctl_pkg::*;
(
  input  wire logic              ref_clk,
  output logic                   selN,       // Chip select, low active
  output logic                   wrN,        // Write strobe, low active
  output logic                   rdN,        // Read strobe, low active
  output logic                   hbs,        // Result half select
  output logic      [DATA_W-1:0] hostData,   // Word the host drives
  output logic                   hostOe,     // High while host drives bus
  output logic                   sampleTick  // Read data is settled
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------
  // Idle levels: deselected, strobes high
  // ----------------------------------------------------------
  initial begin
    selN = 1'b1;
    wrN = 1'b1;
    rdN = 1'b1;
    hbs = 1'b0;
    hostData = '0;
    hostOe = 1'b0;
    sampleTick = 1'b0;
  end
  // Strobe low one cycle; its rise is seen while select still holds selLvl
  task automatic write_word(input logic [DATA_W-1:0] w, input logic selLvl);
    @(posedge ref_clk);
    selN <= selLvl;
    wrN <= 1'b0;
    hostData <= w;
    hostOe <= 1'b1;
    @(posedge ref_clk);
    wrN <= 1'b1;
    @(posedge ref_clk);
    selN <= 1'b1;
    hostOe <= 1'b0;
  endtask
  // Select and read levels set alone; external clock only counts while selected
  task automatic set_pins(input logic s, input logic r);
    @(posedge ref_clk);
    selN <= s;
    rdN <= r;
  endtask
  // Select and read stay low over the whole read, half set with them
  task automatic read_half(input logic h);
    @(posedge ref_clk);
    hbs <= h;
    selN <= 1'b0;
    rdN <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sampleTick <= 1'b1;
    @(posedge ref_clk);
    sampleTick <= 1'b0;
    selN <= 1'b1;
    rdN <= 1'b1;
  endtask
endmodule

// ==== verif/adc_parallel_control_port_tb_top.sv ====
// Self-checking bench for the converter control port
module adc_parallel_control_port_tb_top
  import adc_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              ref_clk, resetn, convClk, compAbove;
  logic              selN, wrN, rdN, hbs, hostOe, sampleTick;
  logic [DATA_W-1:0] hostData, dataIn, dataOut, lastBus;
  logic              dataOeN, doneFlagN, trackHold, negIsCommon, biasOn, converterOn;
  logic [RES_W-1:0]  dacCode, analogLevel, lvl;
  logic [CHAN_W-1:0] posInput, negInput, keepPos;
  localparam int     PWRUP_WAIT = 500000 / CLK_PERIOD_NS; // Reset time and reference settling, 500 us
  localparam int     WAKE_WAIT  = 50000 / CLK_PERIOD_NS;  // Settling after shutdown, external reference
  logic [DATA_W-1:0] expQ[$];   // Expected read bytes, oldest first
  int                err_total, checks_done, cycles;
  // ----------------------------------------------------------
  // Clock, free conversion clock, bus wire and comparator
  // ----------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Conversion clock runs on; ticks in idle must be harmless
  always @(posedge ref_clk) convClk <= ~convClk;
  // Floating bus alternates between the last byte and its complement
  always @(posedge ref_clk) lastBus <= ~dataIn;
  assign dataIn = hostOe ? hostData : (dataOeN === 1'b0 ? dataOut : lastBus);
  assign compAbove = analogLevel >= dacCode;
  host_bus_model u_host (.ref_clk(ref_clk), .selN(selN), .wrN(wrN), .rdN(rdN), .hbs(hbs),
    .hostData(hostData), .hostOe(hostOe), .sampleTick(sampleTick));
  adc_parallel_control_port u_dut (.ref_clk(ref_clk), .resetn(resetn), .deviceSelectN(selN),
    .writeStrobeN(wrN), .readStrobeN(rdN), .highByteSelect(hbs), .convClk(convClk),
    .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN), .doneFlagN(doneFlagN),
    .compAbove(compAbove), .dacCode(dacCode), .trackHold(trackHold), .posInput(posInput),
    .negInput(negInput), .negIsCommon(negIsCommon), .biasOn(biasOn), .converterOn(converterOn));
  // ----------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------
  task automatic check(input string what, input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Monitor takes the oldest note whenever read data is settled
  always @(posedge ref_clk) begin
    if (sampleTick === 1'b1) begin
      check("dataOut", {4'h0, dataOut}, {4'h0, expQ.pop_front()});
    end
  end
  // Hang guard, well above the six thousand four hundred or so cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end
  // Write the word; external acquisition needs a second write to end it
  task automatic start_conv(input logic [DATA_W-1:0] w, input logic [RES_W-1:0] v);
    analogLevel <= v;
    u_host.write_word(w, 1'b0);
    if (w[CTL_ACQ]) begin
      u_host.write_word(w, 1'b0);
    end
  endtask
  // Select held low so an external conversion clock reaches the converter
  task automatic wait_done();
    int n;
    n = 0;
    u_host.set_pins(1'b0, 1'b1);
    while (doneFlagN !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    u_host.set_pins(1'b1, 1'b1);
    check("doneFlagN", doneFlagN, 1'b0);
  endtask
  // One conversion: write, wait for done, read low, high, low again
  task automatic convert(input logic [DATA_W-1:0] w, input logic [RES_W-1:0] v);
    start_conv(w, v);
    wait_done();
    read_result(w, v, w);
  endtask
  // Read the result of word w; cur is the word now in force
  task automatic read_result(input logic [DATA_W-1:0] w, input logic [RES_W-1:0] v,
                             input logic [DATA_W-1:0] cur);
    logic [RES_W-1:0] res;
    res = w[CTL_UNI] ? v : v ^ 12'h800;
    expQ.push_back(res[7:0]);
    u_host.read_half(1'b0);
    check("doneFlagN", doneFlagN, 1'b1);
    expQ.push_back(w[CTL_UNI] ? {4'h0, res[11:8]} : {{4{res[11]}}, res[11:8]});
    u_host.read_half(1'b1);
    expQ.push_back(res[7:0]);
    u_host.read_half(1'b0);
    check("posInput", posInput, cur[2:0]);
    check("negIsCommon", negIsCommon, cur[CTL_SGL]);
    if (!cur[CTL_SGL]) begin
      check("negInput", negInput, cur[2:0] ^ 3'h1);
    end
    check("converterOn", converterOn, cur[CTL_PWR_HI]);
    check("biasOn", biasOn, cur[7:6] != PWR_FULL_DOWN);
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    resetn = 1'b0;
    convClk = 1'b0;
    analogLevel = '0;
    err_total = 0;
    checks_done = 0;
    cycles = 0;
    void'($urandom(32'hfded));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    check("doneFlagN", doneFlagN, 1'b1);
    check("dataOeN", dataOeN, 1'b1);
    // No conversion before reset time and reference settling have passed
    repeat (PWRUP_WAIT) @(posedge ref_clk);
    // First word keeps the reset clock mode, then int and ext alternate
    for (int i = 0; i < 10; i++) begin
      lvl = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom());
      convert({(i % 2 == 0) ? PWR_EXT_CLK : PWR_INT_CLK, 1'b0, 5'($urandom())}, lvl);
    end
    $display("test conversions done");
    // Deselected write must leave the word and phase alone
    keepPos = posInput;
    u_host.write_word(8'h97 ^ {5'h0, posInput}, 1'b1);
    repeat (3) @(posedge ref_clk);
    check("trackHold", trackHold, 1'b0);
    check("posInput", posInput, keepPos);
    check("dataOeN", dataOeN, 1'b1);
    $display("test deselected write done");
    // Overlapped: next word starts acquiring before the last result is read
    start_conv({PWR_INT_CLK, 6'h0e}, 12'h6d2);
    wait_done();
    start_conv({PWR_EXT_CLK, 6'h31}, 12'h1b8);
    read_result({PWR_INT_CLK, 6'h0e}, 12'h6d2, {PWR_EXT_CLK, 6'h31});
    wait_done();
    read_result({PWR_EXT_CLK, 6'h31}, 12'h1b8, {PWR_EXT_CLK, 6'h31});
    $display("test overlapped conversion done");
    // Standby and shutdown entered by a dummy conversion, left by a write
    convert({PWR_STANDBY, 6'h1d}, 12'h5a3);
    convert({PWR_INT_CLK, 6'h12}, 12'h3c7);
    convert({PWR_FULL_DOWN, 6'h0b}, 12'h9e1);
    // Wake by a write, then let the reference settle before trusting codes
    u_host.write_word({PWR_INT_CLK, 6'h04}, 1'b0);
    repeat (WAKE_WAIT) @(posedge ref_clk);
    check("converterOn", converterOn, 1'b1);
    check("biasOn", biasOn, 1'b1);
    // Read strobe with select high must leave flag and bus alone
    u_host.set_pins(1'b1, 1'b0);
    repeat (2) @(posedge ref_clk);
    check("dataOeN", dataOeN, 1'b1);
    check("doneFlagN", doneFlagN, 1'b0);
    u_host.set_pins(1'b1, 1'b1);
    convert({PWR_EXT_CLK, 6'h04}, 12'h7ff);
    $display("test power modes done");
    close_out();
  end
endmodule
